// File: design/pcflow_pkg.sv
// Constants, types and decode helpers shared by the program-flow block
package pcflow_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int PC_WIDTH = 13;
    localparam int DATA_WIDTH = 8;
    localparam int LATCH_WIDTH = 5;
    localparam int BRANCH_WIDTH = 11;
    localparam int MEM_ADDR_WIDTH = 9;
    localparam int STACK_DEPTH = 8;
    localparam int APB_ADDR_WIDTH = 12;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int STATUS_BANK_BIT = 7;
    localparam int LATCH_FAR_HI = 4;
    localparam int LATCH_FAR_LO = 3;
    localparam logic [6:0] PORT_LOW_ADDR = 7'h00;

    // ****************************************
    // APB register offsets
    // ****************************************
    localparam logic [APB_ADDR_WIDTH-1:0] OFS_PC_LOW = 12'h000;
    localparam logic [APB_ADDR_WIDTH-1:0] OFS_HIGH_LATCH = 12'h004;
    localparam logic [APB_ADDR_WIDTH-1:0] OFS_POINTER = 12'h008;
    localparam logic [APB_ADDR_WIDTH-1:0] OFS_STATUS = 12'h00C;
    localparam logic [APB_ADDR_WIDTH-1:0] OFS_PC_FULL = 12'h010;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [PC_WIDTH-1:0] PC_RESET = 13'h0000;
    localparam logic [LATCH_WIDTH-1:0] LATCH_RESET = 5'h00;
    localparam logic [DATA_WIDTH-1:0] POINTER_RESET = 8'h00;
    localparam logic BANK_RESET = 1'b0;
    localparam logic [PC_WIDTH-1:0] IRQ_VECTOR_DEFAULT = 13'h0004;

    // ****************************************
    // Register selection
    // ****************************************
    typedef enum logic [2:0] {
        SFR_NONE = 3'h0,
        SFR_PC_LOW = 3'h1,
        SFR_HIGH_LATCH = 3'h2,
        SFR_POINTER = 3'h3,
        SFR_STATUS = 3'h4,
        SFR_PC_FULL = 3'h5
    } sfr_sel_type;

    function automatic sfr_sel_type decode_offset(input logic [APB_ADDR_WIDTH-1:0] ofs);
        sfr_sel_type sel;
        sel = SFR_NONE;
        unique case (ofs)
            OFS_PC_LOW: sel = SFR_PC_LOW;
            OFS_HIGH_LATCH: sel = SFR_HIGH_LATCH;
            OFS_POINTER: sel = SFR_POINTER;
            OFS_STATUS: sel = SFR_STATUS;
            OFS_PC_FULL: sel = SFR_PC_FULL;
            default: sel = SFR_NONE;
        endcase
        return sel;
    endfunction

endpackage

// File: design/return_stack.sv
// Circular eight-entry hardware return stack
`timescale 1ns/1ns
module return_stack
    import pcflow_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int WIDTH = PC_WIDTH
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Stack operations
    input wire logic push,
    input wire logic pop,
    input wire logic [WIDTH-1:0] push_data,
    output logic [WIDTH-1:0] top_data
);
    localparam int PTR_WIDTH = $clog2(DEPTH);

    logic [WIDTH-1:0] entries [DEPTH];
    logic [PTR_WIDTH-1:0] stack_ptr;
    logic [PTR_WIDTH-1:0] below_ptr;

    // Pointer wraps freely; no overflow or underflow flag exists
    assign below_ptr = stack_ptr - 1'b1;
    assign top_data = entries[below_ptr];

    // ****************************************
    // Pointer
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_ptr <= '0;
        end else if (push) begin
            stack_ptr <= stack_ptr + 1'b1;
        end else if (pop) begin
            stack_ptr <= below_ptr;
        end
    end

    // ****************************************
    // Storage, no reset so it maps to plain memory
    // ****************************************
    always_ff @(posedge pclk) begin
        if (push) begin
            entries[stack_ptr] <= push_data;
        end
    end

endmodule // return_stack

// File: design/indirect_port.sv
// Indirect data port: forms the 9-bit address and drives data memory
`timescale 1ns/1ns
module indirect_port
    import pcflow_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pointer state
    input wire logic [DATA_WIDTH-1:0] file_select_pointer,
    input wire logic bank_select_high_bit,
    // Core request
    input wire logic ind_valid,
    input wire logic ind_write,
    input wire logic [DATA_WIDTH-1:0] ind_wdata,
    output logic ind_done,
    output logic [DATA_WIDTH-1:0] ind_rdata,
    // Data memory
    output logic [MEM_ADDR_WIDTH-1:0] mem_addr,
    output logic mem_re,
    output logic mem_we,
    output logic [DATA_WIDTH-1:0] mem_wdata,
    input wire logic [DATA_WIDTH-1:0] mem_rdata
);
    logic [MEM_ADDR_WIDTH-1:0] eff_addr;
    logic self_hit;
    logic stage_valid;
    logic stage_self;

    assign eff_addr = {bank_select_high_bit, file_select_pointer};
    // The port is mapped in every bank, so only the low seven bits count
    assign self_hit = (eff_addr[6:0] == PORT_LOW_ADDR);

    // ****************************************
    // Memory strobe stage
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_addr <= '0;
            mem_re <= 1'b0;
            mem_we <= 1'b0;
            mem_wdata <= '0;
            stage_valid <= 1'b0;
            stage_self <= 1'b0;
        end else begin
            mem_addr <= eff_addr;
            mem_re <= ind_valid & ~ind_write & ~self_hit;
            mem_we <= ind_valid & ind_write & ~self_hit;
            mem_wdata <= ind_wdata;
            stage_valid <= ind_valid;
            stage_self <= self_hit;
        end
    end

    // ****************************************
    // Answer stage
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ind_done <= 1'b0;
            ind_rdata <= '0;
        end else begin
            ind_done <= stage_valid;
            ind_rdata <= (stage_valid && !stage_self && mem_re) ? mem_rdata : '0;
        end
    end

endmodule // indirect_port

// File: design/program_flow.sv
// Program counter, return stack and indirect addressing of the core
`timescale 1ns/1ns

// Notes on behaviour
// - 13-bit counter, low byte readable and writable
// - Upper bits never written directly; they load from latch, branch target, stack, vector or carry
// - Any reset clears whole program counter
// - Low byte write loads upper from latch[4:0]
// - Call or jump takes top bits from latch[4:3]
// - Eight 13-bit entries, pointer hidden from software
// - Call and interrupt vectoring push the counter
// - Return, literal return, interrupt return pop
// - Push and pop leave latch unchanged
// - Stack wraps, ninth push overwrites first
// - No overflow or underflow status
// - Indirect port accesses memory at pointer
// - Pointer at port itself reads zero
// - Pointer at port itself writes nothing
// - Address is bank bit above pointer
module program_flow
    import pcflow_pkg::*;
#(
    parameter logic [PC_WIDTH-1:0] IRQ_VECTOR = IRQ_VECTOR_DEFAULT
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pcflow_pkg::APB_ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sequencing from the instruction decoder
    input wire logic pc_step,
    input wire logic do_call,
    input wire logic do_goto,
    input wire logic [pcflow_pkg::BRANCH_WIDTH-1:0] branch_target,
    input wire logic return_plain,
    input wire logic return_with_literal,
    input wire logic return_from_interrupt,
    input wire logic irq_vector,
    // Special register writes by instructions
    input wire logic sfr_write,
    input wire pcflow_pkg::sfr_sel_type sfr_sel,
    input wire logic [pcflow_pkg::DATA_WIDTH-1:0] sfr_wdata,
    // Indirect data port
    input wire logic ind_valid,
    input wire logic ind_write,
    input wire logic [pcflow_pkg::DATA_WIDTH-1:0] ind_wdata,
    output logic ind_done,
    output logic [pcflow_pkg::DATA_WIDTH-1:0] ind_rdata,
    // Data memory
    output logic [pcflow_pkg::MEM_ADDR_WIDTH-1:0] mem_addr,
    output logic mem_re,
    output logic mem_we,
    output logic [pcflow_pkg::DATA_WIDTH-1:0] mem_wdata,
    input wire logic [pcflow_pkg::DATA_WIDTH-1:0] mem_rdata,
    // Fetch address
    output logic [pcflow_pkg::PC_WIDTH-1:0] program_counter
);
    import pcflow_pkg::*;

    // ****************************************
    // Architectural state
    // ****************************************
    logic [LATCH_WIDTH-1:0] pc_high_latch;
    logic [DATA_WIDTH-1:0] file_select_pointer;
    logic bank_select_high_bit;

    // ****************************************
    // APB decode
    // ****************************************
    sfr_sel_type apb_sel;
    logic apb_access;
    logic apb_wr_fire;
    logic apb_mapped;
    logic [31:0] next_prdata;

    assign apb_sel = decode_offset(paddr);
    assign apb_access = psel & penable & pready;
    assign apb_wr_fire = apb_access & pwrite;
    assign apb_mapped = (apb_sel != SFR_NONE);

    // ****************************************
    // Merged register writes, decoder first
    // ****************************************
    logic wr_any;
    sfr_sel_type wr_sel;
    logic [DATA_WIDTH-1:0] wr_data;
    logic wr_pc_low;
    logic wr_latch;
    logic wr_pointer;
    logic wr_status;

    // A bus write in the same cycle as an instruction write is dropped;
    // the core owns these registers while it runs.
    assign wr_any = sfr_write | apb_wr_fire;
    assign wr_sel = sfr_write ? sfr_sel : apb_sel;
    assign wr_data = sfr_write ? sfr_wdata : pwdata[DATA_WIDTH-1:0];
    assign wr_pc_low = wr_any & (wr_sel == SFR_PC_LOW);
    assign wr_latch = wr_any & (wr_sel == SFR_HIGH_LATCH);
    assign wr_pointer = wr_any & (wr_sel == SFR_POINTER);
    assign wr_status = wr_any & (wr_sel == SFR_STATUS);

    // ****************************************
    // Stack control
    // ****************************************
    logic any_return;
    logic any_branch;
    logic stack_push;
    logic stack_pop;
    logic [PC_WIDTH-1:0] stack_top;

    assign any_return = return_plain | return_with_literal | return_from_interrupt;
    assign any_branch = do_call | do_goto;
    // Pushed value is the counter as it stands; the decoder advances it first
    assign stack_push = irq_vector | (do_call & ~irq_vector);
    assign stack_pop = any_return & ~irq_vector & ~any_branch;

    // ****************************************
    // Next program counter
    // ****************************************
    logic [PC_WIDTH-1:0] pc_from_branch;
    logic [PC_WIDTH-1:0] pc_from_low_write;
    logic [PC_WIDTH-1:0] pc_from_step;
    logic [PC_WIDTH-1:0] next_program_counter;

    assign pc_from_branch = {pc_high_latch[LATCH_FAR_HI:LATCH_FAR_LO], branch_target};
    assign pc_from_low_write = {pc_high_latch, wr_data};
    assign pc_from_step = program_counter + 1'b1;

    // Priority: vector, branch, return, low-byte write, step
    assign next_program_counter =
        irq_vector ? IRQ_VECTOR :
        any_branch ? pc_from_branch :
        stack_pop ? stack_top :
        wr_pc_low ? pc_from_low_write :
        pc_step ? pc_from_step :
        program_counter;

    // ****************************************
    // Program counter register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_counter <= PC_RESET;
        end else begin
            program_counter <= next_program_counter;
        end
    end

    // ****************************************
    // High latch, pointer and bank bit
    // ****************************************
    // Stack traffic never touches the latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_high_latch <= LATCH_RESET;
        end else if (wr_latch) begin
            pc_high_latch <= wr_data[LATCH_WIDTH-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            file_select_pointer <= POINTER_RESET;
        end else if (wr_pointer) begin
            file_select_pointer <= wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_select_high_bit <= BANK_RESET;
        end else if (wr_status) begin
            bank_select_high_bit <= wr_data[STATUS_BANK_BIT];
        end
    end

    // ****************************************
    // APB read mux
    // ****************************************
    // Stack pointer and depth are deliberately absent from this map
    always_comb begin
        next_prdata = 32'h0000_0000;
        unique case (apb_sel)
            SFR_PC_LOW: next_prdata[DATA_WIDTH-1:0] = program_counter[DATA_WIDTH-1:0];
            SFR_HIGH_LATCH: next_prdata[LATCH_WIDTH-1:0] = pc_high_latch;
            SFR_POINTER: next_prdata[DATA_WIDTH-1:0] = file_select_pointer;
            SFR_STATUS: next_prdata[STATUS_BANK_BIT] = bank_select_high_bit;
            SFR_PC_FULL: next_prdata[PC_WIDTH-1:0] = program_counter;
            SFR_NONE: next_prdata = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // APB answer, no wait states
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~apb_mapped;
            prdata <= (psel & ~penable & ~pwrite) ? next_prdata : 32'h0000_0000;
        end
    end

    // ****************************************
    // Submodules
    // ****************************************
    return_stack #(
        .DEPTH(STACK_DEPTH),
        .WIDTH(PC_WIDTH)
    ) u_return_stack (
        .pclk(pclk),
        .presetn(presetn),
        .push(stack_push),
        .pop(stack_pop),
        .push_data(program_counter),
        .top_data(stack_top)
    );

    indirect_port u_indirect_port (
        .pclk(pclk),
        .presetn(presetn),
        .file_select_pointer(file_select_pointer),
        .bank_select_high_bit(bank_select_high_bit),
        .ind_valid(ind_valid),
        .ind_write(ind_write),
        .ind_wdata(ind_wdata),
        .ind_done(ind_done),
        .ind_rdata(ind_rdata),
        .mem_addr(mem_addr),
        .mem_re(mem_re),
        .mem_we(mem_we),
        .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata)
    );

endmodule // program_flow

// File: verif/data_memory.sv
// Data memory model behind the indirect port
`timescale 1ns/1ns
module data_memory (
    // Clock
    input wire logic pclk,
    // Memory access
    input wire logic [8:0] mem_addr,
    input wire logic mem_re,
    input wire logic mem_we,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] ram [512];
    logic [7:0] last = 8'h00;
    // Contents distinct within a bank only, so a wrong low byte reads wrong
    initial begin
        for (int i = 0; i < 512; i++) begin
            ram[i] = ~i[7:0];
        end
    end
    always @(posedge pclk) begin
        if (mem_we) begin
            ram[mem_addr] <= mem_wdata;
        end
        if (mem_re) begin
            last <= ram[mem_addr];
        end
    end
    // Idle bus flips, never a stale match
    assign mem_rdata = mem_re ? ram[mem_addr] : ~last;
endmodule // data_memory

// File: verif/program_flow_props.sv
// Port checks of the program-flow block
`timescale 1ns/1ns
module flow_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Sequencing
    input wire logic do_call,
    input wire logic do_goto,
    input wire logic [10:0] branch_target,
    input wire logic return_plain,
    input wire logic return_with_literal,
    input wire logic return_from_interrupt,
    input wire logic irq_vector,
    input wire logic sfr_write,
    input wire pcflow_pkg::sfr_sel_type sfr_sel,
    input wire logic [7:0] sfr_wdata,
    // Indirect port
    input wire logic ind_valid,
    input wire logic [7:0] ind_wdata,
    input wire logic ind_done,
    input wire logic [7:0] ind_rdata,
    input wire logic [8:0] mem_addr,
    input wire logic mem_re,
    input wire logic mem_we,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic [12:0] program_counter
);
    import pcflow_pkg::*;
    logic [4:0] lat;
    logic ret;
    logic jmp;
    assign ret = return_plain | return_with_literal | return_from_interrupt;
    assign jmp = (do_call | do_goto) & ~irq_vector;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Latch shadow; an instruction write beats APB
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat <= '0;
        end else if (sfr_write && sfr_sel == SFR_HIGH_LATCH) begin
            lat <= sfr_wdata[4:0];
        end else if (!sfr_write && psel && penable && pready && pwrite
                && paddr == OFS_HIGH_LATCH) begin
            lat <= pwdata[4:0];
        end
    end
    a_reset_clear: assert property (disable iff (1'b0) !presetn |=> program_counter == '0)
        else $error("counter not cleared");
    a_call_target: assert property (jmp |=> program_counter == {$past(lat[4:3]),
        $past(branch_target)}) else $error("bad jump target");
    a_vector_jump: assert property (irq_vector |=> program_counter == IRQ_VECTOR_DEFAULT)
        else $error("bad vector");
    a_low_write: assert property (sfr_write && sfr_sel == SFR_PC_LOW && !jmp && !ret
        && !irq_vector |=> program_counter == {$past(lat), $past(sfr_wdata)})
        else $error("bad low byte load");
    a_call_return: assert property (jmp && do_call ##1 return_plain && !do_call && !do_goto
        && !irq_vector |=> program_counter == $past(program_counter, 2))
        else $error("bad return address");
    a_ind_done: assert property (ind_valid |-> ##2 ind_done)
        else $error("indirect access not done");
    a_strobe_addr: assert property (mem_re || mem_we |-> mem_addr[6:0] != 7'h00)
        else $error("port reached itself");
    a_self_zero: assert property (ind_done && !$past(mem_re) |-> ind_rdata == 8'h00)
        else $error("self read not zero");
    a_read_data: assert property (mem_re |=> ind_done && ind_rdata == $past(mem_rdata))
        else $error("bad indirect read data");
    a_write_data: assert property (mem_we |-> !mem_re && mem_wdata == $past(ind_wdata))
        else $error("bad indirect write data");
endmodule // flow_props

// File: verif/program_flow_tb_top.sv
// Self-checking bench of the program-flow block
`timescale 1ns/1ns
module program_flow_tb_top;
    import pcflow_pkg::*;
    localparam logic [6:0] IRQ = 7'h40, CALL = 7'h20, JUMP = 7'h10, RET = 7'h08;
    localparam logic [6:0] RETLIT = 7'h04, RETINT = 7'h02;
    logic [6:0] pops [3] = '{RET, RETLIT, RETINT};
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdv;
    logic pready, pslverr, errv, ind_done, mem_re, mem_we;
    logic [6:0] ctl = '0;
    logic [10:0] tgt = '0;
    logic sfr_write = 1'b0, ind_valid = 1'b0, ind_write = 1'b0, step = 1'b0;
    sfr_sel_type sfr_sel = SFR_NONE;
    logic [7:0] sfr_wdata = '0, ind_wdata = '0, ind_rdata, mem_rdata, mem_wdata;
    logic [8:0] mem_addr;
    logic [12:0] program_counter;
    int n_errors = 0;
    int num_checks = 0;
    always #50 pclk = ~pclk;
    program_flow uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pc_step(step), .do_call(ctl[5]), .do_goto(ctl[4]),
        .branch_target(tgt), .return_plain(ctl[3]), .return_with_literal(ctl[2]),
        .return_from_interrupt(ctl[1]), .irq_vector(ctl[6]), .sfr_write, .sfr_sel,
        .sfr_wdata, .ind_valid, .ind_write, .ind_wdata, .ind_done, .ind_rdata, .mem_addr,
        .mem_re, .mem_we, .mem_wdata, .mem_rdata, .program_counter);
    data_memory mem (.pclk, .mem_addr, .mem_re, .mem_we, .mem_wdata, .mem_rdata);
    task automatic finish_test;
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    // Zero-wait slave, but the wait stays bounded
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        repeat (8) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (pready !== 1'b1) begin
            n_errors++;
            finish_test;
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, '0);
        cmp(what, e, rdv);
    endtask
    task automatic run(input logic [6:0] v, input logic [10:0] t, input logic [12:0] e);
        @(posedge pclk);
        ctl <= v;
        tgt <= t;
        @(posedge pclk);
        ctl <= '0;
        #1 cmp("program_counter", e, program_counter);
    endtask
    task automatic ind(input logic w, input logic [7:0] d, input logic [7:0] e);
        @(posedge pclk);
        ind_valid <= 1'b1;
        ind_write <= w;
        ind_wdata <= d;
        @(posedge pclk);
        ind_valid <= 1'b0;
        @(posedge pclk);
        #1 cmp("ind_done", 1'b1, ind_done);
        cmp("ind_rdata", e, ind_rdata);
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd("full pc", OFS_PC_FULL, '0);
        apb(1'b0, 12'h040, '0);
        cmp("pslverr", 1'b1, errv);
        apb(1'b1, OFS_HIGH_LATCH, 32'h1F);
        apb(1'b1, OFS_PC_LOW, 32'h34);
        rd("full pc", OFS_PC_FULL, 13'h1F34);
        rd("pc low", OFS_PC_LOW, 8'h34);
        run(CALL, 11'h5AB, 13'h1DAB);
        rd("high latch", OFS_HIGH_LATCH, 8'h1F);
        run(RET, '0, 13'h1F34);
        @(posedge pclk);
        sfr_write <= 1'b1;
        sfr_sel <= SFR_HIGH_LATCH;
        sfr_wdata <= 8'h0A;
        @(posedge pclk);
        sfr_sel <= SFR_PC_LOW;
        sfr_wdata <= 8'hC3;
        @(posedge pclk);
        sfr_write <= 1'b0;
        #1 cmp("program_counter", 13'h0AC3, program_counter);
        run(JUMP, 11'h7FF, 13'h0FFF);
        run(IRQ, '0, 13'h0004);
        run(RETINT, '0, 13'h0FFF);
        @(posedge pclk);
        ctl <= CALL;
        tgt <= 11'h010;
        run(RET, '0, 13'h0FFF);
        apb(1'b1, OFS_HIGH_LATCH, '0);
        for (int i = 1; i <= 10; i++) begin
            run(JUMP, 11'(i), 13'(i));
            run(CALL, 11'h100, 13'h0100);
        end
        // Ten pushes: the oldest two are gone
        for (int i = 0; i < 9; i++) begin
            run(pops[i % 3], '0, (i == 8) ? 13'h000A : 13'(10 - i));
        end
        @(posedge pclk);
        step <= 1'b1;
        @(posedge pclk);
        step <= 1'b0;
        #1 cmp("program_counter", 13'h000B, program_counter);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        #1 cmp("program_counter", '0, program_counter);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, OFS_POINTER, 32'h25);
        apb(1'b1, OFS_STATUS, 32'h80);
        rd("pointer", OFS_POINTER, 32'h25);
        rd("status", OFS_STATUS, 32'h80);
        ind(1'b1, 8'hA5, 8'h00);
        cmp("memory", 8'hA5, mem.ram[9'h125]);
        ind(1'b0, 8'h00, 8'hA5);
        apb(1'b1, OFS_POINTER, '0);
        apb(1'b1, OFS_STATUS, '0);
        ind(1'b1, 8'h5A, 8'h00);
        cmp("memory", 8'hFF, mem.ram[9'h000]);
        ind(1'b0, 8'h00, 8'h00);
        finish_test;
    end
endmodule // program_flow_tb_top
bind program_flow flow_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .do_call, .do_goto, .branch_target, .return_plain,
    .return_with_literal, .return_from_interrupt, .irq_vector, .sfr_write, .sfr_sel,
    .sfr_wdata, .ind_valid, .ind_wdata, .ind_done, .ind_rdata, .mem_addr, .mem_re, .mem_we,
    .mem_wdata, .mem_rdata, .program_counter);
